/* inc/lens_ctl_defs.vh */
// constants for the lens driver serial control block
// assumes a 50 MHz core clock and a bus master that samples data on the clock's rising edge
// How it works
// RULE1 - power-up clears every register to zero; device starts asleep
// RULE2 - active_pin low holds registers reset and disables the serial interface
// RULE3 - active_pin high with sleep_bar zero means sleep mode
// RULE4 - power mode register at 0x00 holds sleep_bar in bit 0
// RULE5 - software writes zeros into reserved bits 7 down to 1
// RULE6 - sleep entry and exit keep all register contents
// RULE7 - peak level register at 0x01 sets amplitude; zero gives no output
// RULE8 - lens outputs swap polarity at about 1.1 kHz
// RULE9 - slave only; data line open drain, clock line input only
// RULE10 - start, address with direction, register address, data bytes, stop
// RULE11 - start is data falling with clock high; stop is data rising
// RULE12 - data stays stable while clock high; one bit per clock pulse
// RULE13 - ninth clocked bit is the acknowledge, receiver holds data low
// RULE14 - device acknowledges written bytes; master acknowledges read bytes
// RULE15 - respond to address byte 0xEC for write, 0xED for read
// RULE16 - stop after register address only loads the pointer
// RULE17 - write data goes to pointer register, pointer then increments
// RULE18 - reads return pointer register, pointer increments after each byte
// RULE19 - master sets pointer with address-only write before reading
// RULE20 - after master not-acknowledge the device releases the data line
// RULE21 - foreign address bytes are ignored and not acknowledged
// RULE22 - writes above 0x01 ignored, reads return zero, pointer still counts
`ifndef LENS_CTL_DEFS_VH
`define LENS_CTL_DEFS_VH

// ==========================================================
// bus addressing
`define DEV_ADDR7 7'h76
`define REG_POWER_MODE 8'h00
`define REG_PEAK_LEVEL 8'h01
`define SLEEP_BAR_BIT 0

// ==========================================================
// reset values
`define POWER_MODE_RST 8'h00
`define PEAK_LEVEL_RST 8'h00

// ==========================================================
// timing: half period of the bridge toggle, 1.1 kHz nominal
`define CLK_HZ 50000000
`define TOGGLE_HZ 1100
`define TOGGLE_HALF_CYC (`CLK_HZ / (2 * `TOGGLE_HZ))

`endif

/* rtl/lens_reg_file.v */
// two-entry byte register file for the lens driver control block
// assumes writes and reads come from the serial engine on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "lens_ctl_defs.vh"

module lens_reg_file
(
  // clock and clear
  input wire core_clk,
  input wire clear,
  // access port
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  // register contents
  output reg [7:0] power_mode,
  output reg [7:0] peak_output_level
);

  // ==========================================================
  // storage; only the clear resets it, sleep leaves it alone
  always @(posedge core_clk)
  begin
    if (clear)
    begin
      power_mode <= `POWER_MODE_RST; // see RULE1
      peak_output_level <= `PEAK_LEVEL_RST; // see RULE2
    end
    else if (wr_en)
    begin
      if (addr == `REG_POWER_MODE)
        power_mode <= wdata;
      else if (addr == `REG_PEAK_LEVEL)
        peak_output_level <= wdata; // see RULE17
    end
    // other addresses are silently dropped, see RULE22
  end

  // registered read data, zero for unmapped addresses
  always @(posedge core_clk)
  begin
    if (clear)
      rdata <= 8'h00;
    else if (addr == `REG_POWER_MODE)
      rdata <= power_mode;
    else if (addr == `REG_PEAK_LEVEL)
      rdata <= peak_output_level; // see RULE18
    else
      rdata <= 8'h00; // see RULE22
  end

endmodule // lens_reg_file

`default_nettype wire

/* rtl/lens_driver_i2c_control.v */
// serial slave control for the lens driver: bus engine, mode logic, bridge toggle
// assumes the bus pins are open drain with pull-ups, and both toggle far slower than core_clk
`timescale 1ns/1ps
`default_nettype none
`include "lens_ctl_defs.vh"

module lens_driver_i2c_control
#(
  parameter TOGGLE_HALF = `TOGGLE_HALF_CYC
)
(
  // clock and power-up reset
  input wire core_clk,
  input wire rst_n,
  // enable pin
  input wire active_pin,
  // serial bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  // lens drive
  output reg lens_drive_a,
  output reg lens_drive_b,
  output reg [7:0] peak_level_code,
  // status
  output reg sleep_mode
);

  // ==========================================================
  // engine states
  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_DEV = 7'b0000010;
  localparam [6:0] ST_DEV_ACK = 7'b0000100;
  localparam [6:0] ST_WRX = 7'b0001000;
  localparam [6:0] ST_WR_ACK = 7'b0010000;
  localparam [6:0] ST_RDX = 7'b0100000;
  localparam [6:0] ST_RD_ACK = 7'b1000000;

  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] en_sync;
  reg scl_d;
  reg sda_d;
  reg [6:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] pointer;
  reg got_ptr;
  reg drive_low;
  reg reg_wr;
  reg [7:0] tx;
  reg [15:0] tog_cnt;
  reg phase;
  wire clear;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire [7:0] rdata;
  wire [7:0] power_mode;
  wire [7:0] peak_output_level;
  wire sleep_bar;

  // pointer advance, used on write and read
  function [7:0] next_ptr;
    input [7:0] p;
    begin
      next_ptr = p + 8'h01;
    end
  endfunction

  // ==========================================================
  // synchronisers: pins come from outside core_clk
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      en_sync <= 2'b00;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      en_sync <= {en_sync[0], active_pin};
    end
  end

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  // power-up or enable low both force the clear
  assign clear = !rst_n || !en_sync[1]; // see RULE1, see RULE2

  // edge history of the synchronised lines
  always @(posedge core_clk)
  begin
    if (clear)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // start and stop: data moving while clock high
  assign start_seen = scl_s && scl_d && sda_d && !sda_s; // see RULE11
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s; // see RULE11

  // ==========================================================
  // register file
  lens_reg_file u_regs
  (
    .core_clk(core_clk),
    .clear(clear),
    .wr_en(reg_wr),
    .addr(pointer),
    .wdata(shreg),
    .rdata(rdata),
    .power_mode(power_mode),
    .peak_output_level(peak_output_level)
  );

  assign sleep_bar = power_mode[`SLEEP_BAR_BIT]; // see RULE4

  // ==========================================================
  // bus engine; bits sampled on clock rise, driven after clock fall
  always @(posedge core_clk)
  begin
    reg_wr <= 1'b0;
    if (clear)
    begin
      state <= ST_IDLE; // interface disabled while held, see RULE2
      bit_cnt <= 4'd0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      got_ptr <= 1'b0;
      drive_low <= 1'b0;
      tx <= 8'h00;
    end
    else if (start_seen)
    begin
      // start or repeated start begins the address byte, see RULE10
      state <= ST_DEV;
      bit_cnt <= 4'd0;
      drive_low <= 1'b0;
    end
    else if (stop_seen)
    begin
      // a stop after only the register address leaves just the pointer, see RULE16
      state <= ST_IDLE;
      drive_low <= 1'b0;
    end
    else
    begin
      case (state)
        ST_DEV:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s}; // see RULE12
            bit_cnt <= bit_cnt + 4'd1;
          end
          else if (scl_fall && bit_cnt == 4'd8)
          begin
            bit_cnt <= 4'd0;
            if (shreg[7:1] == `DEV_ADDR7) // see RULE15
            begin
              drive_low <= 1'b1; // see RULE14
              state <= ST_DEV_ACK;
            end
            else
              state <= ST_IDLE; // see RULE21
          end
        end
        ST_DEV_ACK:
        begin
          if (scl_fall)
          begin
            if (shreg[0])
            begin
              // read: first byte from the stored pointer, see RULE18
              tx <= rdata;
              drive_low <= !rdata[7];
              bit_cnt <= 4'd1;
              state <= ST_RDX;
            end
            else
            begin
              drive_low <= 1'b0;
              got_ptr <= 1'b0;
              state <= ST_WRX;
            end
          end
        end
        ST_WRX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'd1;
          end
          else if (scl_fall && bit_cnt == 4'd8)
          begin
            bit_cnt <= 4'd0;
            drive_low <= 1'b1; // acknowledge every written byte, see RULE13
            state <= ST_WR_ACK;
            if (!got_ptr)
            begin
              pointer <= shreg;
              got_ptr <= 1'b1;
            end
            else
              reg_wr <= 1'b1; // see RULE17
          end
        end
        ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            drive_low <= 1'b0;
            state <= ST_WRX;
            if (got_ptr && reg_wr == 1'b0 && bit_cnt == 4'd0)
              pointer <= pointer;
          end
          if (reg_wr)
            pointer <= next_ptr(pointer); // see RULE17, see RULE22
        end
        ST_RDX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'd8)
            begin
              drive_low <= 1'b0; // release for the master's acknowledge
              pointer <= next_ptr(pointer); // see RULE18
              state <= ST_RD_ACK;
            end
            else
            begin
              drive_low <= !tx[3'd7 - bit_cnt[2:0]];
              bit_cnt <= bit_cnt + 4'd1;
            end
          end
        end
        ST_RD_ACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              state <= ST_IDLE; // not-acknowledge: stop sending, see RULE20
            else
            begin
              tx <= rdata;
              bit_cnt <= 4'd0;
            end
          end
          else if (scl_fall && bit_cnt == 4'd0)
          begin
            drive_low <= !tx[7];
            bit_cnt <= 4'd1;
            state <= ST_RDX;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // open-drain data line: only ever pulls low, clock never driven, see RULE9
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_low;

  // ==========================================================
  // mode and amplitude; sleep never touches the stored values, see RULE6
  always @(posedge core_clk)
  begin
    if (clear)
    begin
      sleep_mode <= 1'b1;
      peak_level_code <= 8'h00;
    end
    else
    begin
      sleep_mode <= !sleep_bar; // see RULE3
      // outputs parked at zero amplitude while asleep, see RULE7
      peak_level_code <= sleep_bar ? peak_output_level : 8'h00;
    end
  end

  // ==========================================================
  // bridge toggle; held idle in sleep or with zero code to avoid stray pulses
  always @(posedge core_clk)
  begin
    if (clear || !sleep_bar || peak_output_level == 8'h00)
    begin
      tog_cnt <= 16'd0;
      phase <= 1'b0;
      lens_drive_a <= 1'b0;
      lens_drive_b <= 1'b0;
    end
    else
    begin
      if (tog_cnt == TOGGLE_HALF[15:0] - 16'd1)
      begin
        tog_cnt <= 16'd0;
        phase <= !phase; // see RULE8
      end
      else
        tog_cnt <= tog_cnt + 16'd1;
      lens_drive_a <= phase;
      lens_drive_b <= !phase;
    end
  end

endmodule // lens_driver_i2c_control

`default_nettype wire

/* tb/i2c_master_model.sv */
// bus master model: serial clock and data with a pulled-up data wire
// assumes core_clk paces it; one bit takes 8 cycles, 160 ns
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
  // clock
  input wire logic core_clk,
  // bus
  output logic scl,
  output logic sda_drv,
  output wire logic sda,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  // ======
  // wire level: pull-up wins unless someone pulls low
  assign sda = sda_drv & (sda_oe_n | sda_out);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // data falls with clock high, then clock drops
  task start;
  begin
    @(posedge core_clk) sda_drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    scl <= 1'b0;
  end
  endtask
  // data moves only while the clock is low
  task bit_io(input logic b, output logic r);
  begin
    @(posedge core_clk) sda_drv <= b;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (3) @(posedge core_clk);
    r = sda;
    @(posedge core_clk) scl <= 1'b0;
  end
  endtask
  // eight bits msb first plus the ninth acknowledge bit
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    integer i;
  begin
    for (i = 8; i >= 0; i = i - 1)
      bit_io(tx[i], rx[i]);
  end
  endtask
  // data rises with clock high
  task stop;
  begin
    @(posedge core_clk) sda_drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (3) @(posedge core_clk);
    sda_drv <= 1'b1;
    repeat (3) @(posedge core_clk);
  end
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* tb/lens_ctl_chk.sv */
// port checker for the lens control block
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module lens_ctl_chk
#(
  parameter TOGGLE_HALF = 20
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins
  input wire logic active_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic lens_drive_a,
  input wire logic lens_drive_b,
  input wire logic [7:0] peak_level_code,
  input wire logic sleep_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] hi_cnt;
  // ======
  // length of the bridge high phase so far
  always_ff @(posedge core_clk)
    hi_cnt <= lens_drive_a ? hi_cnt + 16'h0001 : 16'h0000;
  // sync delay of the pin is two flops, so allow five samples
  chk_shutdown_quiet: assert property (!active_pin [*5] |-> sda_oe_n && sleep_mode)
    else $error("outputs active in shutdown");
  chk_sleep_code: assert property (sleep_mode [*2] |-> peak_level_code == 8'h00)
    else $error("code while asleep");
  chk_sleep_bridge: assert property (sleep_mode [*3] |-> !lens_drive_a && !lens_drive_b)
    else $error("bridge runs asleep");
  chk_zero_idle: assert property ((peak_level_code == 8'h00) [*3] |-> !lens_drive_a)
    else $error("bridge runs at code zero");
  chk_drive_compl: assert property (lens_drive_a |-> !lens_drive_b)
    else $error("both outputs high");
  chk_run_toggle: assert property ((!sleep_mode && peak_level_code != 8'h00) [*4]
    |-> lens_drive_a != lens_drive_b)
    else $error("bridge idle while running");
  chk_half_bound: assert property (lens_drive_a |-> hi_cnt < TOGGLE_HALF)
    else $error("bridge half period too long");
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("data driven high");
  chk_ack_stable: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
    |-> $stable(sda_oe_n))
    else $error("data moved with clock high");
  cover property ($fell(sda_oe_n));
  cover property ($rose(lens_drive_a));
  cover property ($fell(sleep_mode));
endmodule // lens_ctl_chk
bind lens_driver_i2c_control lens_ctl_chk #(.TOGGLE_HALF(TOGGLE_HALF)) u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .active_pin(active_pin), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .lens_drive_a(lens_drive_a),
  .lens_drive_b(lens_drive_b), .peak_level_code(peak_level_code), .sleep_mode(sleep_mode)
);
`default_nettype wire

/* tb/tb.sv */
// bench for the lens control block: register traffic over the serial bus
// assumes the master model and the bound checker sit beside the block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] HALF = 8'h14;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic active_pin = 1'b1;
  wire logic scl, sda_drv, sda, sda_out, sda_oe_n, drv_a, drv_b, sleep_mode;
  wire logic [7:0] code;
  integer n_errors = 0;
  integer check_count = 0;
  integer k;
  logic [8:0] rx;
  // ======
  always #10 core_clk = ~core_clk;
  lens_driver_i2c_control #(.TOGGLE_HALF(20)) u_dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .active_pin(active_pin), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .lens_drive_a(drv_a),
    .lens_drive_b(drv_b), .peak_level_code(code), .sleep_mode(sleep_mode)
  );
  i2c_master_model u_master
  (
    .core_clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n)
  );
  task chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      n_errors = n_errors + 1;
  end
  endtask
  // address byte, pointer, then n data bytes; nak means no acknowledge expected
  task wr(input logic [7:0] adr, p, input integer n, input logic [7:0] d0, d1, input logic nak);
    integer i;
  begin
    u_master.start;
    u_master.xfer({adr, 1'b1}, rx);
    chk(rx[0], nak);
    if (!nak)
      u_master.xfer({p, 1'b1}, rx);
    for (i = 0; i < n && !nak; i = i + 1)
      u_master.xfer({i ? d1 : d0, 1'b1}, rx);
    chk(rx[0], nak);
    u_master.stop;
  end
  endtask
  // n bytes read, the last one refused by the master
  task rd(input integer n, input logic [7:0] e0, e1);
    integer i;
  begin
    u_master.start;
    u_master.xfer({8'hED, 1'b1}, rx);
    chk(rx[0], 1'b0);
    for (i = 0; i < n; i = i + 1)
    begin
      u_master.xfer({8'hFF, i == n - 1}, rx);
      chk(rx[8:1], i ? e1 : e0);
    end
    repeat (6) @(posedge core_clk);
    chk(sda_oe_n, 1'b1);
    // extra clocks after the refusal must find the data line left to the pull-up
    u_master.xfer({8'hFF, 1'b1}, rx);
    chk(rx[8:1], 8'hFF);
    u_master.stop;
  end
  endtask
  task t_regs;
  begin
    chk(sleep_mode, 1'b1);
    wr(8'hEC, 8'h00, 0, 8'h00, 8'h00, 1'b0);
    rd(2, 8'h00, 8'h00);
    wr(8'hEC, 8'h00, 2, 8'h01, 8'hA5, 1'b0);
    chk(sleep_mode, 1'b0);
    chk(code, 8'hA5);
    wr(8'hEC, 8'h01, 0, 8'h00, 8'h00, 1'b0);
    chk(code, 8'hA5);
    rd(2, 8'hA5, 8'h00);
    wr(8'hEC, 8'h01, 2, 8'h3C, 8'h77, 1'b0);
    wr(8'hEC, 8'h00, 0, 8'h00, 8'h00, 1'b0);
    rd(2, 8'h01, 8'h3C);
  end
  endtask
  task t_sleep;
  begin
    wr(8'hEC, 8'h00, 1, 8'h00, 8'h00, 1'b0);
    chk(sleep_mode, 1'b1);
    chk(code, 8'h00);
    wr(8'hEC, 8'h00, 1, 8'h01, 8'h00, 1'b0);
    chk(code, 8'h3C);
  end
  endtask
  // count one full high phase of the bridge
  task t_bridge;
  begin
    for (k = 0; drv_a && k < 200; k = k + 1)
      @(posedge core_clk);
    for (k = 0; !drv_a && k < 200; k = k + 1)
      @(posedge core_clk);
    for (k = 0; drv_a && k < 200; k = k + 1)
      @(posedge core_clk);
    chk(k[7:0], HALF);
    chk(drv_b, 1'b1);
  end
  endtask
  task t_off;
  begin
    wr(8'hEE, 8'h00, 1, 8'h00, 8'h00, 1'b1);
    chk(code, 8'h3C);
    active_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(8'hEC, 8'h00, 1, 8'h01, 8'h00, 1'b1);
    active_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(8'hEC, 8'h00, 0, 8'h00, 8'h00, 1'b0);
    rd(2, 8'h00, 8'h00);
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // main sequence; reset is synchronous, so release it on an edge
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_regs;
    t_sleep;
    t_bridge;
    t_off;
    stop_test;
  end
  // a hung handshake lands here, far past the expected run
  initial
  begin
    repeat (30000) @(posedge core_clk);
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule // tb
`default_nettype wire
